// ===== hdl/isdc_consts.vh
// Purpose: offsets, field positions, reset values for the start-up config bank
// Assumes: included once per design file by bare name
// Notes: definitions only, no logic
`ifndef ISDC_CONSTS_VH
`define ISDC_CONSTS_VH

// register offsets on the serial memory address
`define ISDC_ADDR_W 12
`define ISDC_OFS_SPEED_DETECT 12'h080
`define ISDC_OFS_REVERSE_DRIVE 12'h082
`define ISDC_RESET_VALUE 32'h00000000

// speed_detect_config fields
`define ISDC_SD_RSVD 31
`define ISDC_SD_ON 30
`define ISDC_SD_BRAKE_ON 29
`define ISDC_SD_COAST_ON 28
`define ISDC_SD_REVERSAL_ON 27
`define ISDC_SD_RESYNC_ON 26
`define ISDC_SD_RESYNC_LVL 25:22
`define ISDC_SD_BRAKE_SIDE 21
`define ISDC_SD_BRAKE_EXIT 20
`define ISDC_SD_BRAKE_CUR 19:17
`define ISDC_SD_BRAKE_DUR 16:13
`define ISDC_SD_COAST_DUR 12:9
`define ISDC_SD_STAT_EMF 8:6
`define ISDC_SD_HANDOVER 5:2
`define ISDC_SD_REV_CUR 1:0

// reverse_drive_config fields
`define ISDC_RD_RSVD 31
`define ISDC_RD_LIN_ACC 30:27
`define ISDC_RD_QUAD_ACC 26:23
`define ISDC_RD_AB_CUR 22:20
`define ISDC_RD_AB_KP 19:10
`define ISDC_RD_AB_KI 9:0

// fractional bits of the active-brake gains
`define ISDC_KP_FRAC_BITS 7
`define ISDC_KI_FRAC_BITS 9

// table selectors for the speed-level decoder
`define ISDC_TBL_RESYNC 1'b0
`define ISDC_TBL_HANDOVER 1'b1

`endif

// ===== hdl/isdc_duration_dec.v
// Purpose: turn a 4-bit phase duration code into milliseconds
// Assumes: code is a stored register field, so output is registered
// Notes: shared by brake duration and coast duration
`timescale 1ns/100ps
`include "isdc_consts.vh"

module isdc_duration_dec (
	input wire clk,
	input wire rst,
	input wire [3:0] code,
	output reg [13:0] ms_q
);

	// sixteen durations, 10 ms up to 15 s
	function [13:0] dur_ms;
		input [3:0] c;
		begin
			case (c)
				4'h0: dur_ms = 14'd10;
				4'h1: dur_ms = 14'd50;
				4'h2: dur_ms = 14'd100;
				4'h3: dur_ms = 14'd200;
				4'h4: dur_ms = 14'd300;
				4'h5: dur_ms = 14'd400;
				4'h6: dur_ms = 14'd500;
				4'h7: dur_ms = 14'd750;
				4'h8: dur_ms = 14'd1000;
				4'h9: dur_ms = 14'd2000;
				4'ha: dur_ms = 14'd3000;
				4'hb: dur_ms = 14'd4000;
				4'hc: dur_ms = 14'd5000;
				4'hd: dur_ms = 14'd7500;
				4'he: dur_ms = 14'd10000;
				default: dur_ms = 14'd15000;
			endcase
		end
	endfunction

	// register the lookup; reset matches code zero
	always @(posedge clk) begin
		if (rst) begin
			ms_q <= 14'd10;
		end else begin
			ms_q <= dur_ms(code);
		end
	end

endmodule

// ===== hdl/isdc_speed_dec.v
// Purpose: turn a 4-bit speed level code into tenths of a percent
// Assumes: TABLE picks resync or handover scale
// Notes: output is in 0.1 % of maximum speed, registered
`timescale 1ns/100ps
`include "isdc_consts.vh"

module isdc_speed_dec #(
	parameter TABLE = `ISDC_TBL_RESYNC
) (
	input wire clk,
	input wire rst,
	input wire [3:0] code,
	output reg [9:0] permille_q
);

	// resync scale: 5 % steps to 60 %, then 70..100 %
	function [9:0] resync_pm;
		input [3:0] c;
		begin
			if (c < 4'hc) begin
				resync_pm = 10'd50 * {6'h00, c} + 10'd50;
			end else begin
				resync_pm = 10'd100 * {6'h00, c} - 10'd500;
			end
		end
	endfunction

	// handover scale: 2.5 % steps to 15 %, then irregular upper steps
	function [9:0] handover_pm;
		input [3:0] c;
		begin
			case (c)
				4'h6: handover_pm = 10'd200;
				4'h7: handover_pm = 10'd250;
				4'h8: handover_pm = 10'd300;
				4'h9: handover_pm = 10'd400;
				4'ha: handover_pm = 10'd500;
				4'hb: handover_pm = 10'd600;
				4'hc: handover_pm = 10'd700;
				4'hd: handover_pm = 10'd800;
				4'he: handover_pm = 10'd900;
				4'hf: handover_pm = 10'd1000;
				default: handover_pm = 10'd25 * {6'h00, c} + 10'd25;
			endcase
		end
	endfunction

	// reset value is that of code zero on the chosen scale
	always @(posedge clk) begin
		if (rst) begin
			permille_q <= (TABLE == `ISDC_TBL_RESYNC) ? 10'd50 : 10'd25;
		end else if (TABLE == `ISDC_TBL_RESYNC) begin
			permille_q <= resync_pm(code);
		end else begin
			permille_q <= handover_pm(code);
		end
	end

endmodule

// ===== hdl/isdc_regs.v
// Purpose: start-up speed detection and reverse drive configuration bank
// Assumes: the serial link layer delivers decoded word accesses here
// Notes: fields are exported raw and decoded into physical units
`timescale 1ns/100ps
`include "isdc_consts.vh"

module isdc_regs #(
	parameter ADDR_W = `ISDC_ADDR_W
) (
	input wire clk,
	input wire rst,
	// word access from the serial register interface
	input wire [ADDR_W-1:0] mem_addr,
	input wire wr_en,
	input wire [31:0] wr_data,
	input wire rd_en,
	output reg [31:0] rd_data_q,
	output reg rd_valid_q,
	output wire addr_hit,
	// effective phase controls
	output reg speed_detect_on_q,
	output reg brake_phase_on_q,
	output reg coast_phase_on_q,
	output reg reversal_on_q,
	output reg resync_on_q,
	output reg brake_side_select_q,
	output reg brake_exit_select_q,
	// decoded levels
	output wire [9:0] resync_speed_permille,
	output wire [9:0] handover_speed_permille,
	output wire [13:0] brake_duration_ms,
	output wire [13:0] coast_duration_ms,
	output reg [7:0] brake_current_sixteenths_q,
	output reg [10:0] stationary_emf_mv_q,
	output reg [5:0] reversal_current_sixteenths_q,
	output reg [5:0] active_brake_limit_sixteenths_q,
	output reg active_brake_limit_bad_q,
	output reg [19:0] reversal_linear_accel_centi_q,
	output reg [19:0] reversal_quadratic_accel_centi_q,
	output reg [9:0] active_brake_prop_gain_q,
	output reg [9:0] active_brake_int_gain_q
);

	reg [31:0] speed_detect_config_q; // word at 80h
	reg [31:0] reverse_drive_config_q; // word at 82h
	reg [31:0] rd_mux; // read data before the output flop
	wire hit_sd; // address selects speed_detect_config
	wire hit_rd; // address selects reverse_drive_config

	// exact offset match; every other offset is treated as reserved
	assign hit_sd = (mem_addr == `ISDC_OFS_SPEED_DETECT);
	assign hit_rd = (mem_addr == `ISDC_OFS_REVERSE_DRIVE);
	assign addr_hit = hit_sd | hit_rd;

	// brake exit current threshold in 1/16 A, 0.0625 A to 5 A
	function [7:0] brake_cur_lvl;
		input [2:0] c;
		begin
			case (c)
				3'h0: brake_cur_lvl = 8'd1;
				3'h1: brake_cur_lvl = 8'd2;
				3'h2: brake_cur_lvl = 8'd3;
				3'h3: brake_cur_lvl = 8'd5;
				3'h4: brake_cur_lvl = 8'd10;
				3'h5: brake_cur_lvl = 8'd20;
				3'h6: brake_cur_lvl = 8'd40;
				default: brake_cur_lvl = 8'd80;
			endcase
		end
	endfunction

	// stationary back-emf threshold in mV
	function [10:0] emf_mv;
		input [2:0] c;
		begin
			case (c)
				3'h0: emf_mv = 11'd50;
				3'h1: emf_mv = 11'd75;
				3'h2: emf_mv = 11'd100;
				3'h3: emf_mv = 11'd250;
				3'h4: emf_mv = 11'd500;
				3'h5: emf_mv = 11'd750;
				3'h6: emf_mv = 11'd1000;
				default: emf_mv = 11'd1500;
			endcase
		end
	endfunction

	// open-loop current while reversing, in 1/16 A
	function [5:0] rev_cur;
		input [1:0] c;
		begin
			case (c)
				2'h0: rev_cur = 6'd15;
				2'h1: rev_cur = 6'd25;
				2'h2: rev_cur = 6'd35;
				default: rev_cur = 6'd50;
			endcase
		end
	endfunction

	// active brake bus limit in 1/16 A; code 7 gives zero
	function [5:0] ab_lim;
		input [2:0] c;
		begin
			case (c)
				3'h0: ab_lim = 6'd5;
				3'h1: ab_lim = 6'd10;
				3'h2: ab_lim = 6'd20;
				3'h3: ab_lim = 6'd30;
				3'h4: ab_lim = 6'd40;
				3'h5: ab_lim = 6'd50;
				3'h6: ab_lim = 6'd60;
				default: ab_lim = 6'd0;
			endcase
		end
	endfunction

	// acceleration in 0.01 Hz/s (or Hz/s^2); code 0 differs per field
	function [19:0] accel_centi;
		input [3:0] c;
		input [19:0] zero_val;
		begin
			case (c)
				4'h0: accel_centi = zero_val;
				4'h1: accel_centi = 20'd5;
				4'h2: accel_centi = 20'd100;
				4'h3: accel_centi = 20'd250;
				4'h4: accel_centi = 20'd500;
				4'h5: accel_centi = 20'd1000;
				4'h6: accel_centi = 20'd2500;
				4'h7: accel_centi = 20'd5000;
				4'h8: accel_centi = 20'd7500;
				4'h9: accel_centi = 20'd10000;
				4'ha: accel_centi = 20'd25000;
				4'hb: accel_centi = 20'd50000;
				4'hc: accel_centi = 20'd75000;
				4'hd: accel_centi = 20'd100000;
				4'he: accel_centi = 20'd500000;
				default: accel_centi = 20'd1000000;
			endcase
		end
	endfunction

	// register writes; whole word, bit 31 stored but unused
	always @(posedge clk) begin
		if (rst) begin
			speed_detect_config_q <= `ISDC_RESET_VALUE;
			reverse_drive_config_q <= `ISDC_RESET_VALUE;
		end else if (wr_en) begin
			if (hit_sd) begin
				speed_detect_config_q <= wr_data;
			end
			if (hit_rd) begin
				reverse_drive_config_q <= wr_data;
			end
		end
	end

	// read mux; unmapped offsets read as zero
	always @* begin
		rd_mux = 32'h00000000;
		if (hit_sd) begin
			rd_mux = speed_detect_config_q;
		end else if (hit_rd) begin
			rd_mux = reverse_drive_config_q;
		end
	end

	// read data is held until the next read; valid is a pulse
	always @(posedge clk) begin
		if (rst) begin
			rd_data_q <= 32'h00000000;
			rd_valid_q <= 1'b0;
		end else begin
			rd_valid_q <= rd_en;
			if (rd_en) begin
				rd_data_q <= rd_mux;
			end
		end
	end

	// phase controls: sub-phases only act while detection is on,
	// so one bit can park the whole sequence without losing setup
	always @(posedge clk) begin
		if (rst) begin
			speed_detect_on_q <= 1'b0;
			brake_phase_on_q <= 1'b0;
			coast_phase_on_q <= 1'b0;
			reversal_on_q <= 1'b0;
			resync_on_q <= 1'b0;
			brake_side_select_q <= 1'b0;
			brake_exit_select_q <= 1'b0;
		end else begin
			speed_detect_on_q <= speed_detect_config_q[`ISDC_SD_ON];
			brake_phase_on_q <= speed_detect_config_q[`ISDC_SD_ON] &
				speed_detect_config_q[`ISDC_SD_BRAKE_ON];
			coast_phase_on_q <= speed_detect_config_q[`ISDC_SD_ON] &
				speed_detect_config_q[`ISDC_SD_COAST_ON];
			reversal_on_q <= speed_detect_config_q[`ISDC_SD_ON] &
				speed_detect_config_q[`ISDC_SD_REVERSAL_ON];
			resync_on_q <= speed_detect_config_q[`ISDC_SD_ON] &
				speed_detect_config_q[`ISDC_SD_RESYNC_ON];
			// zero: three high-side switches, one: three low-side
			brake_side_select_q <=
				speed_detect_config_q[`ISDC_SD_BRAKE_SIDE];
			// zero: time only, one: current and time
			brake_exit_select_q <=
				speed_detect_config_q[`ISDC_SD_BRAKE_EXIT];
		end
	end

	// physical-unit levels; reset values equal those of code zero
	always @(posedge clk) begin
		if (rst) begin
			brake_current_sixteenths_q <= 8'd1;
			stationary_emf_mv_q <= 11'd50;
			reversal_current_sixteenths_q <= 6'd15;
			active_brake_limit_sixteenths_q <= 6'd5;
			active_brake_limit_bad_q <= 1'b0;
			reversal_linear_accel_centi_q <= 20'd1;
			reversal_quadratic_accel_centi_q <= 20'd0;
			active_brake_prop_gain_q <= 10'h000;
			active_brake_int_gain_q <= 10'h000;
		end else begin
			brake_current_sixteenths_q <= brake_cur_lvl(
				speed_detect_config_q[`ISDC_SD_BRAKE_CUR]);
			stationary_emf_mv_q <= emf_mv(
				speed_detect_config_q[`ISDC_SD_STAT_EMF]);
			reversal_current_sixteenths_q <= rev_cur(
				speed_detect_config_q[`ISDC_SD_REV_CUR]);
			active_brake_limit_sixteenths_q <= ab_lim(
				reverse_drive_config_q[`ISDC_RD_AB_CUR]);
			// flag the reserved code rather than invent a limit
			active_brake_limit_bad_q <=
				&reverse_drive_config_q[`ISDC_RD_AB_CUR];
			reversal_linear_accel_centi_q <= accel_centi(
				reverse_drive_config_q[`ISDC_RD_LIN_ACC], 20'd1);
			reversal_quadratic_accel_centi_q <= accel_centi(
				reverse_drive_config_q[`ISDC_RD_QUAD_ACC], 20'd0);
			// raw gains: kp is q3.7, ki is q1.9 fixed point
			active_brake_prop_gain_q <=
				reverse_drive_config_q[`ISDC_RD_AB_KP];
			active_brake_int_gain_q <=
				reverse_drive_config_q[`ISDC_RD_AB_KI];
		end
	end

	// bit 31 of either word is kept for readback only, it drives nothing

	// resync minimum speed decoder
	isdc_speed_dec #(
		.TABLE(`ISDC_TBL_RESYNC)
	) u_resync_lvl (
		.clk(clk),
		.rst(rst),
		.code(speed_detect_config_q[`ISDC_SD_RESYNC_LVL]),
		.permille_q(resync_speed_permille)
	);

	// reversal handover speed decoder
	isdc_speed_dec #(
		.TABLE(`ISDC_TBL_HANDOVER)
	) u_handover_lvl (
		.clk(clk),
		.rst(rst),
		.code(speed_detect_config_q[`ISDC_SD_HANDOVER]),
		.permille_q(handover_speed_permille)
	);

	// brake duration decoder
	isdc_duration_dec u_brake_dur (
		.clk(clk),
		.rst(rst),
		.code(speed_detect_config_q[`ISDC_SD_BRAKE_DUR]),
		.ms_q(brake_duration_ms)
	);

	// coast duration decoder, same table as braking
	isdc_duration_dec u_coast_dur (
		.clk(clk),
		.rst(rst),
		.code(speed_detect_config_q[`ISDC_SD_COAST_DUR]),
		.ms_q(coast_duration_ms)
	);

endmodule

// ===== test/isdc_regs_properties.sv
// Purpose: port-level properties of the start-up config bank
// Assumes: word access port of isdc_regs, one clock
// Notes: fields lag a write by two edges, so checks look two back
`timescale 1ns/100ps
`include "isdc_consts.vh"
module isdc_regs_chk #(
	parameter ADDR_W = 12
) (
	input wire logic clk,
	input wire logic rst,
	input wire logic [ADDR_W-1:0] mem_addr,
	input wire logic wr_en,
	input wire logic [31:0] wr_data,
	input wire logic rd_en,
	input wire logic [31:0] rd_data_q,
	input wire logic rd_valid_q,
	input wire logic addr_hit,
	input wire logic speed_detect_on_q,
	input wire logic brake_phase_on_q,
	input wire logic coast_phase_on_q,
	input wire logic reversal_on_q,
	input wire logic resync_on_q,
	input wire logic brake_side_select_q,
	input wire logic brake_exit_select_q,
	input wire logic active_brake_limit_bad_q,
	input wire logic [9:0] active_brake_prop_gain_q
);
	default clocking cb @(posedge clk); endclocking
	default disable iff (rst);
	// write strobes per word
	wire sd_w = wr_en && mem_addr == `ISDC_OFS_SPEED_DETECT;
	wire rv_w = wr_en && mem_addr == `ISDC_OFS_REVERSE_DRIVE;
	// a lone write; a second one would move the expected value
	sequence s_sd_wr;
		sd_w ##1 !sd_w;
	endsequence
	sequence s_rv_wr;
		rv_w ##1 !rv_w;
	endsequence
	// write then read of the same word
	sequence s_wr_rd;
		sd_w ##1 (rd_en && !wr_en && mem_addr == `ISDC_OFS_SPEED_DETECT);
	endsequence
	property p_sd_on;
		s_sd_wr |=> speed_detect_on_q == $past(wr_data[30], 2);
	endproperty
	a_sd_on: assert property (p_sd_on) else $error("detect enable");
	property p_brake;
		s_sd_wr |=> brake_phase_on_q ==
			($past(wr_data[30], 2) && $past(wr_data[29], 2));
	endproperty
	a_brake: assert property (p_brake) else $error("brake enable");
	property p_gates;
		s_sd_wr |=> {coast_phase_on_q, reversal_on_q, resync_on_q} ==
			({3{$past(wr_data[30], 2)}} & $past(wr_data[28:26], 2));
	endproperty
	a_gates: assert property (p_gates) else $error("phase gates");
	property p_side;
		s_sd_wr |=> {brake_side_select_q, brake_exit_select_q} ==
			$past(wr_data[21:20], 2);
	endproperty
	a_side: assert property (p_side) else $error("brake selects");
	property p_kp;
		s_rv_wr |=> active_brake_prop_gain_q == $past(wr_data[19:10], 2);
	endproperty
	a_kp: assert property (p_kp) else $error("prop gain");
	property p_bad;
		s_rv_wr |=> active_brake_limit_bad_q ==
			($past(wr_data[22:20], 2) == 3'h7);
	endproperty
	a_bad: assert property (p_bad) else $error("limit flag");
	property p_rd_pulse;
		rd_en |=> rd_valid_q;
	endproperty
	a_rd_pulse: assert property (p_rd_pulse) else $error("no valid");
	property p_rd_hold;
		!rd_en |=> !rd_valid_q && $stable(rd_data_q);
	endproperty
	a_rd_hold: assert property (p_rd_hold) else $error("read moved");
	property p_unmapped;
		rd_en && !addr_hit |=> rd_data_q == 32'h0;
	endproperty
	a_unmapped: assert property (p_unmapped) else $error("hole read");
	property p_readback;
		s_wr_rd |=> rd_data_q == $past(wr_data, 2);
	endproperty
	a_readback: assert property (p_readback) else $error("readback");
endmodule
bind isdc_regs isdc_regs_chk #(.ADDR_W(ADDR_W)) chk_u (
	.clk(clk), .rst(rst), .mem_addr(mem_addr), .wr_en(wr_en),
	.wr_data(wr_data), .rd_en(rd_en), .rd_data_q(rd_data_q),
	.rd_valid_q(rd_valid_q), .addr_hit(addr_hit),
	.speed_detect_on_q(speed_detect_on_q),
	.brake_phase_on_q(brake_phase_on_q),
	.coast_phase_on_q(coast_phase_on_q), .reversal_on_q(reversal_on_q),
	.resync_on_q(resync_on_q), .brake_side_select_q(brake_side_select_q),
	.brake_exit_select_q(brake_exit_select_q),
	.active_brake_limit_bad_q(active_brake_limit_bad_q),
	.active_brake_prop_gain_q(active_brake_prop_gain_q)
);

// ===== test/isdc_regs_tb.sv
// Purpose: self-checking bench for the start-up config bank
// Assumes: isdc_regs, inputs driven on the falling edge
// Notes: a word model predicts reads; tables predict decodes
`timescale 1ns/100ps
`include "isdc_consts.vh"
module isdc_regs_tb;
	// code tables in the output units chosen by the design
	localparam int DUR[16] = '{10, 50, 100, 200, 300, 400, 500, 750,
		1000, 2000, 3000, 4000, 5000, 7500, 10000, 15000};
	localparam int RSY[16] = '{50, 100, 150, 200, 250, 300, 350, 400,
		450, 500, 550, 600, 700, 800, 900, 1000};
	localparam int HND[16] = '{25, 50, 75, 100, 125, 150, 200, 250,
		300, 400, 500, 600, 700, 800, 900, 1000};
	localparam int ACC[16] = '{1, 5, 100, 250, 500, 1000, 2500, 5000,
		7500, 10000, 25000, 50000, 75000, 100000, 500000, 1000000};
	localparam int BCU[8] = '{1, 2, 3, 5, 10, 20, 40, 80};
	localparam int EMF[8] = '{50, 75, 100, 250, 500, 750, 1000, 1500};
	localparam int ABL[8] = '{5, 10, 20, 30, 40, 50, 60, 0};
	localparam int RCU[4] = '{15, 25, 35, 50};
	logic clk = 0;
	logic rst = 1;
	logic wr_en = 0;
	logic rd_en = 0;
	logic [11:0] mem_addr = 0;
	logic [31:0] wr_data = 0;
	logic [31:0] sd_m = 0; // model of speed_detect_config
	logic [31:0] rv_m = 0; // model of reverse_drive_config
	logic [31:0] exp_rd;
	int fails = 0;
	int tests_run = 0;
	// outputs are read through the instance path
	isdc_regs dut_u (
		.clk(clk), .rst(rst), .mem_addr(mem_addr), .wr_en(wr_en),
		.wr_data(wr_data), .rd_en(rd_en), .rd_data_q(), .rd_valid_q(),
		.addr_hit(), .speed_detect_on_q(), .brake_phase_on_q(),
		.coast_phase_on_q(), .reversal_on_q(), .resync_on_q(),
		.brake_side_select_q(), .brake_exit_select_q(),
		.resync_speed_permille(), .handover_speed_permille(),
		.brake_duration_ms(), .coast_duration_ms(),
		.brake_current_sixteenths_q(), .stationary_emf_mv_q(),
		.reversal_current_sixteenths_q(),
		.active_brake_limit_sixteenths_q(), .active_brake_limit_bad_q(),
		.reversal_linear_accel_centi_q(),
		.reversal_quadratic_accel_centi_q(),
		.active_brake_prop_gain_q(), .active_brake_int_gain_q()
	);
	// free-running clock, 8 ns
	initial begin
		forever #4 clk = ~clk;
	end
	// resync scale: 5 % steps to 60 %, then 10 % steps
	function automatic int resync_exp(input logic [3:0] c);
		return RSY[c];
	endfunction
	// quadratic term starts at zero, linear at 0.01
	function automatic int quad_exp(input logic [3:0] c);
		return (c == 0) ? 0 : ACC[c];
	endfunction
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		tests_run++;
		if (got !== exp) begin
			fails++;
			$display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask
	// one cycle on the word port; caller sits on a falling edge
	task automatic acc(input logic w, input logic r, input logic [11:0] a,
		input logic [31:0] d);
		wr_en = w;
		rd_en = r;
		mem_addr = a;
		wr_data = d;
		// a read in the write cycle still sees the old word
		exp_rd = (a == 12'h080) ? sd_m : (a == 12'h082) ? rv_m : 32'h0;
		if (w && a == 12'h080)
			sd_m = d;
		if (w && a == 12'h082)
			rv_m = d;
		@(negedge clk);
		// the address still stands here, so the decode can be seen
		chk(dut_u.addr_hit, a == 12'h080 || a == 12'h082);
		chk(dut_u.rd_valid_q, r);
		if (r)
			chk(dut_u.rd_data_q, exp_rd);
	endtask
	// idle two edges so decodes settle, then compare every field
	task automatic settle();
		logic [31:0] s;
		logic [31:0] v;
		acc(1'b0, 1'b0, 12'h000, 32'h0);
		acc(1'b0, 1'b0, 12'h000, 32'h0);
		s = sd_m;
		v = rv_m;
		chk(dut_u.speed_detect_on_q, s[30]);
		chk(dut_u.brake_phase_on_q, s[30] & s[29]);
		chk(dut_u.coast_phase_on_q, s[30] & s[28]);
		chk(dut_u.reversal_on_q, s[30] & s[27]);
		chk(dut_u.resync_on_q, s[30] & s[26]);
		chk(dut_u.resync_speed_permille, resync_exp(s[25:22]));
		chk(dut_u.brake_side_select_q, s[21]);
		chk(dut_u.brake_exit_select_q, s[20]);
		chk(dut_u.brake_current_sixteenths_q, BCU[s[19:17]]);
		chk(dut_u.brake_duration_ms, DUR[s[16:13]]);
		chk(dut_u.coast_duration_ms, DUR[s[12:9]]);
		chk(dut_u.stationary_emf_mv_q, EMF[s[8:6]]);
		chk(dut_u.handover_speed_permille, HND[s[5:2]]);
		chk(dut_u.reversal_current_sixteenths_q, RCU[s[1:0]]);
		chk(dut_u.reversal_linear_accel_centi_q, ACC[v[30:27]]);
		chk(dut_u.reversal_quadratic_accel_centi_q, quad_exp(v[26:23]));
		chk(dut_u.active_brake_limit_sixteenths_q, ABL[v[22:20]]);
		chk(dut_u.active_brake_limit_bad_q, v[22:20] == 3'h7);
		chk(dut_u.active_brake_prop_gain_q, v[19:10]);
		chk(dut_u.active_brake_int_gain_q, v[9:0]);
	endtask
	// reset for 12 cycles; the model clears with it
	task automatic rst_dut();
		rst = 1'b1;
		repeat (12) @(negedge clk);
		rst = 1'b0;
		sd_m = 32'h0;
		rv_m = 32'h0;
		// reset must also clear the held read word and its pulse
		chk(dut_u.rd_data_q, 32'h0);
		chk(dut_u.rd_valid_q, 1'b0);
	endtask
	task automatic end_sim();
		$display("compares %0d mismatches %0d", tests_run, fails);
		if (fails == 0 && tests_run > 0)
			$display("ALL CHECKS OK");
		else
			$display("CHECKS NOT OK");
		$finish;
	endtask
	initial begin
		logic [31:0] w;
		logic [31:0] v;
		logic [1:0] k;
		void'($urandom(32'had29));
		@(negedge clk);
		rst_dut();
		acc(1'b0, 1'b1, 12'h080, 32'h0);
		acc(1'b0, 1'b1, 12'h082, 32'h0);
		settle();
		$display("test reset done");
		// every code of every table; fields differ to catch swaps
		for (int c = 0; c < 16; c++) begin
			w = $urandom;
			v = $urandom;
			w[25:22] = c[3:0];
			w[19:17] = c[2:0];
			w[16:13] = c[3:0];
			w[12:9] = ~c[3:0];
			w[8:6] = ~c[2:0];
			w[5:2] = c[3:0];
			w[1:0] = c[1:0];
			v[30:27] = c[3:0];
			v[26:23] = ~c[3:0];
			v[22:20] = c[2:0];
			acc(1'b1, 1'b0, 12'h080, w);
			acc(1'b1, 1'b1, 12'h082, v);
			acc(1'b0, 1'b1, 12'h080, 32'h0);
			settle();
		end
		$display("test tables done");
		// random back-to-back traffic, holes included
		for (int i = 0; i < 400; i++) begin
			k = 2'($urandom);
			w = $urandom;
			acc(k[0], k[1], (w[0] ? 12'h080 : w[1] ? 12'h082 : w[11:0]),
				$urandom);
			if (i % 20 == 19)
				settle();
		end
		$display("test random done");
		// reset in mid-run clears both words
		acc(1'b1, 1'b0, 12'h080, 32'hffffffff);
		acc(1'b1, 1'b0, 12'h082, 32'hffffffff);
		rst_dut();
		acc(1'b0, 1'b1, 12'h080, 32'h0);
		acc(1'b0, 1'b1, 12'h082, 32'h0);
		settle();
		$display("test rerun reset done");
		end_sim();
	end
	// hang guard, far beyond the few hundred cycles needed
	initial begin
		#200000;
		fails++;
		end_sim();
	end
endmodule
